// >>> common/accept_filter_pkg.sv
// Constants, register map and carrier types of the acceptance filter block
`default_nettype none

package accept_filter_pkg;

  // Sizes
  localparam int FILTER_COUNT = 16;
  localparam int MASK_COUNT   = 3;
  localparam int SID_W        = 11;
  localparam int EID_W        = 18;
  localparam int BP_W         = 4;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 16;

  // Register word offsets
  localparam logic [7:0] FILT_SID_BASE  = 8'h00;
  localparam logic [7:0] FILT_EID_BASE  = 8'h10;
  localparam logic [7:0] MSEL_LOW_ADDR  = 8'h20;
  localparam logic [7:0] MSEL_HIGH_ADDR = 8'h21;
  localparam logic [7:0] MASK_SID_BASE  = 8'h24;
  localparam logic [7:0] MASK_EID_BASE  = 8'h28;
  localparam logic [7:0] BUFPTR_BASE    = 8'h2C;
  localparam logic [7:0] STATUS_ADDR    = 8'h30;

  // Field positions in the identifier words; filters per mask-select word and pointers per buffer-pointer word
  localparam int SID_LSB     = 5;
  localparam int TYPE_BIT    = 3;
  localparam int EIDHI_LSB   = 0;
  localparam int FILTS_PER_SEL = 8;
  localparam int PTRS_PER_REG  = 4;

  // Reset values
  localparam logic [15:0] MSEL_RESET   = 16'h0000;
  localparam logic [15:0] BUFPTR_RESET = 16'h0000;

  // Mask source codes and buffer pointer codes
  localparam logic [1:0]  MSRC_MASK0 = 2'h0;
  localparam logic [1:0]  MSRC_MASK1 = 2'h1;
  localparam logic [1:0]  MSRC_MASK2 = 2'h2;
  localparam logic [3:0]  BP_FIFO    = 4'hF;

  typedef struct packed {
    logic [SID_W-1:0] standard_identifier_bits;
    logic [EID_W-1:0] extended_identifier_bits;
    logic             ide;
  } frame_type;

  typedef struct packed {
    logic [SID_W-1:0] standard_identifier_bits;
    logic             filter_extended_enable;
    logic [EID_W-1:0] extended_identifier_bits;
  } filter_cfg_type;

  typedef struct packed {
    logic [SID_W-1:0] standard_identifier_bits;
    logic             identifier_type_match_mode;
    logic [EID_W-1:0] extended_identifier_bits;
  } mask_cfg_type;

  typedef struct packed {
    filter_cfg_type [FILTER_COUNT-1:0]      filt;
    mask_cfg_type   [MASK_COUNT-1:0]        mask;
    logic           [2*FILTER_COUNT-1:0]    msel;
    logic           [FILTER_COUNT-1:0][3:0] bufptr;
    logic           [DATA_W-1:0]            rdata;
    logic                                   hit_valid;
    logic                                   reject_valid;
    logic           [3:0]                   hit_filter;
    logic           [3:0]                   hit_bufptr;
    logic                                   hit_to_fifo;
    logic                                   seen;
    logic           [3:0]                   last_filter;
    logic           [3:0]                   last_bufptr;
  } core_state_type;

endpackage

`default_nettype wire

// >>> src/accept_filter.sv
// Acceptance filter bank with its register file and hit routing
`default_nettype none

module accept_filter
  import accept_filter_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Received frame from the protocol engine
  input  wire logic              frame_valid,
  input  wire frame_type         frame,
  // Acceptance result
  output logic                   hit_valid,
  output logic                   reject_valid,
  output logic      [3:0]        hit_filter,
  output logic      [3:0]        hit_bufptr,
  output logic                   hit_to_fifo
);

  ////////////////////////////////////////////////////////////////////////////

  core_state_type              st_r;
  core_state_type              st_nxt;
  logic [FILTER_COUNT-1:0]     hits;
  mask_cfg_type [FILTER_COUNT-1:0] sel_mask;
  logic                        any_hit;
  logic [3:0]                  win;

  // Mask chosen by a two-bit source code; reserved code falls back to mask 0
  function automatic mask_cfg_type pick_mask(
    input logic [1:0]                     code,
    input mask_cfg_type [MASK_COUNT-1:0] masks
  );
    mask_cfg_type m;
    m = masks[0];
    case (code)
      MSRC_MASK0: m = masks[0];
      MSRC_MASK1: m = masks[1];
      MSRC_MASK2: m = masks[2];
      default:    m = masks[0];
    endcase
    return m;
  endfunction

  // Standard-identifier word image; unimplemented bits read zero
  function automatic logic [DATA_W-1:0] sid_word(
    input logic [SID_W-1:0] standard_identifier_bits,
    input logic             flag,
    input logic [1:0]       eid_hi
  );
    return {standard_identifier_bits, 1'b0, flag, 1'b0, eid_hi};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Filter bank

  genvar g;
  generate
    for (g = 0; g < FILTER_COUNT; g++)
    begin : g_filt
      always_comb
      begin
        sel_mask[g] = pick_mask(st_r.msel[2*g+1:2*g],
                                st_r.mask);
      end

      filter_match u_match (
        .filt  (st_r.filt[g]),
        .mask  (sel_mask[g]),
        .frame (frame),
        .hit   (hits[g])
      );
    end
  endgenerate

  // Lowest-numbered hitting filter wins
  always_comb
  begin
    any_hit = |hits;
    win     = 4'h0;
    for (int i = FILTER_COUNT - 1; i >= 0; i--)
    begin
      if (hits[i])
      begin
        win = 4'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_nxt              = st_r;
    st_nxt.rdata        = '0;
    st_nxt.hit_valid    = 1'b0;
    st_nxt.reject_valid = 1'b0;

    if (reg_wr)
    begin
      for (int i = 0; i < FILTER_COUNT; i++)
      begin
        if (reg_addr == FILT_SID_BASE + 8'(i))
        begin
          st_nxt.filt[i].standard_identifier_bits        = reg_wdata[15:SID_LSB];
          st_nxt.filt[i].filter_extended_enable      = reg_wdata[TYPE_BIT];
          st_nxt.filt[i].extended_identifier_bits[17:16] = reg_wdata[EIDHI_LSB+:2];
        end
        if (reg_addr == FILT_EID_BASE + 8'(i))
        begin
          st_nxt.filt[i].extended_identifier_bits[15:0] = reg_wdata;
        end
      end
      for (int i = 0; i < MASK_COUNT; i++)
      begin
        if (reg_addr == MASK_SID_BASE + 8'(i))
        begin
          // Bits 4 and 2 have no storage
          st_nxt.mask[i].standard_identifier_bits        = reg_wdata[15:SID_LSB];
          st_nxt.mask[i].identifier_type_match_mode       = reg_wdata[TYPE_BIT];
          st_nxt.mask[i].extended_identifier_bits[17:16] = reg_wdata[EIDHI_LSB+:2];
        end
        if (reg_addr == MASK_EID_BASE + 8'(i))
        begin
          st_nxt.mask[i].extended_identifier_bits[15:0] = reg_wdata;
        end
      end
      for (int i = 0; i < FILTER_COUNT / PTRS_PER_REG; i++)
      begin
        if (reg_addr == BUFPTR_BASE + 8'(i))
        begin
          st_nxt.bufptr[4*i+:4] = reg_wdata;
        end
      end
      if (reg_addr == MSEL_LOW_ADDR)
      begin
        st_nxt.msel[15:0] = reg_wdata;
      end
      if (reg_addr == MSEL_HIGH_ADDR)
      begin
        st_nxt.msel[31:16] = reg_wdata;
      end
    end

    if (reg_rd)
    begin
      for (int i = 0; i < FILTER_COUNT; i++)
      begin
        if (reg_addr == FILT_SID_BASE + 8'(i))
        begin
          st_nxt.rdata = sid_word(st_r.filt[i].standard_identifier_bits, st_r.filt[i].filter_extended_enable,
                                  st_r.filt[i].extended_identifier_bits[17:16]);
        end
        if (reg_addr == FILT_EID_BASE + 8'(i))
        begin
          st_nxt.rdata = st_r.filt[i].extended_identifier_bits[15:0];
        end
      end
      for (int i = 0; i < MASK_COUNT; i++)
      begin
        if (reg_addr == MASK_SID_BASE + 8'(i))
        begin
          st_nxt.rdata = sid_word(st_r.mask[i].standard_identifier_bits, st_r.mask[i].identifier_type_match_mode,
                                  st_r.mask[i].extended_identifier_bits[17:16]);
        end
        if (reg_addr == MASK_EID_BASE + 8'(i))
        begin
          st_nxt.rdata = st_r.mask[i].extended_identifier_bits[15:0];
        end
      end
      for (int i = 0; i < FILTER_COUNT / PTRS_PER_REG; i++)
      begin
        if (reg_addr == BUFPTR_BASE + 8'(i))
        begin
          st_nxt.rdata = st_r.bufptr[4*i+:4];
        end
      end
      if (reg_addr == MSEL_LOW_ADDR)
      begin
        st_nxt.rdata = st_r.msel[15:0];
      end
      if (reg_addr == MSEL_HIGH_ADDR)
      begin
        st_nxt.rdata = st_r.msel[31:16];
      end
      if (reg_addr == STATUS_ADDR)
      begin
        st_nxt.rdata = {7'h00, st_r.seen, st_r.last_filter, st_r.last_bufptr};
      end
    end

    if (frame_valid)
    begin
      st_nxt.hit_valid    = any_hit;
      st_nxt.reject_valid = !any_hit;
      if (any_hit)
      begin
        st_nxt.hit_filter  = win;
        st_nxt.hit_bufptr  = st_r.bufptr[win];
        st_nxt.hit_to_fifo = (st_r.bufptr[win] == BP_FIFO);
        st_nxt.seen        = 1'b1;
        st_nxt.last_filter = win;
        st_nxt.last_bufptr = st_r.bufptr[win];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; identifier registers are left unreset

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_r.msel         <= {MSEL_RESET, MSEL_RESET};
      st_r.bufptr       <= {4{BUFPTR_RESET}};
      st_r.rdata        <= '0;
      st_r.hit_valid    <= 1'b0;
      st_r.reject_valid <= 1'b0;
      st_r.hit_filter   <= 4'h0;
      st_r.hit_bufptr   <= 4'h0;
      st_r.hit_to_fifo  <= 1'b0;
      st_r.seen         <= 1'b0;
      st_r.last_filter  <= 4'h0;
      st_r.last_bufptr  <= 4'h0;
      st_r.filt         <= st_nxt.filt;
      st_r.mask         <= st_nxt.mask;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata    = st_r.rdata;
  assign hit_valid    = st_r.hit_valid;
  assign reject_valid = st_r.reject_valid;
  assign hit_filter   = st_r.hit_filter;
  assign hit_bufptr   = st_r.hit_bufptr;
  assign hit_to_fifo  = st_r.hit_to_fifo;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  mask_cfg_type m0;
  assign m0 = sel_mask[0];

  chk_msel_reset: assert property (
    @(posedge clk_sys) $past(rst) |-> st_r.msel == '0)
    else $error("mask selection not zero after reset");

  chk_unimpl_zero: assert property (
    reg_rd && reg_addr >= MASK_SID_BASE && reg_addr < MASK_SID_BASE + 8'h03
    |=> reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("unimplemented mask bits read nonzero");

  chk_msel_write: assert property (
    reg_wr && reg_addr == MSEL_LOW_ADDR
    |=> ##1 reg_rd && reg_addr == MSEL_LOW_ADDR
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mask selection readback differs");

  chk_sid_equal: assert property (
    frame_valid && hits[0]
    |-> ((frame.standard_identifier_bits ^ st_r.filt[0].standard_identifier_bits) & m0.standard_identifier_bits) == '0)
    else $error("hit with differing included standard bit");

  chk_eid_equal: assert property (
    frame_valid && frame.ide && hits[0]
    |-> ((frame.extended_identifier_bits ^ st_r.filt[0].extended_identifier_bits) & m0.extended_identifier_bits) == '0)
    else $error("hit with differing included extended bit");

  chk_type_mode: assert property (
    frame_valid && m0.identifier_type_match_mode && hits[0] |-> frame.ide == st_r.filt[0].filter_extended_enable)
    else $error("type mode hit with wrong frame type");

  chk_mask_pick: assert property (
    st_r.msel[1:0] == MSRC_MASK1 |-> m0 == st_r.mask[1])
    else $error("filter 0 not using mask 1");

  chk_hit_route: assert property (
    frame_valid && any_hit
    |=> hit_valid && hit_bufptr == $past(st_r.bufptr[win])
        && hit_to_fifo == (hit_bufptr == BP_FIFO))
    else $error("hit routed to wrong buffer");

  chk_hit_cause: assert property (
    hit_valid |-> $past(frame_valid)
                  && (($past(hits) >> hit_filter) & FILTER_COUNT'(1)) != '0
                  && !reject_valid)
    else $error("hit without a matching filter");

  chk_reject: assert property (
    frame_valid && hits == '0 |=> reject_valid && !hit_valid)
    else $error("unmatched frame not rejected");

  cov_hit_fifo:   cover property (hit_valid && hit_to_fifo);
  cov_hit_buffer: cover property (hit_valid && !hit_to_fifo);
  cov_reject:     cover property (reject_valid);
  cov_type_mode:  cover property (frame_valid && m0.identifier_type_match_mode && hits[0]);

endmodule

`default_nettype wire

// >>> src/filter_match.sv
// One acceptance filter compared against a received identifier
`default_nettype none

module filter_match
  import accept_filter_pkg::*;
(
  // Configuration
  input  wire filter_cfg_type filt,
  input  wire mask_cfg_type   mask,
  // Received identifier
  input  wire frame_type      frame,
  // Result
  output logic                hit
);

  logic sid_ok;
  logic eid_ok;
  logic id_ok;

  always_comb
  begin
    // Excluded bits never block a hit
    sid_ok = ((frame.standard_identifier_bits ^ filt.standard_identifier_bits) & mask.standard_identifier_bits) == '0;
    eid_ok = ((frame.extended_identifier_bits ^ filt.extended_identifier_bits) & mask.extended_identifier_bits) == '0;
    id_ok  = sid_ok && (!frame.ide || eid_ok);
    if (mask.identifier_type_match_mode)
    begin
      hit = id_ok && (frame.ide == filt.filter_extended_enable);
    end
    else
    begin
      hit = id_ok;
    end
  end

endmodule

`default_nettype wire

// >>> verification/can_frame_source.sv
// Remote node model that hands received identifiers to the filter
`default_nettype none

module can_frame_source
  import accept_filter_pkg::*;
(
  // Clock
  input  wire logic clk_sys,
  // Identifier towards the filter
  output logic      frame_valid,
  output frame_type frame
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    frame_valid = 1'b0;
    frame       = '0;
  end

  // One identifier per pulse; the lines are scrambled once released
  task automatic send(input frame_type f);
    @(posedge clk_sys);
    frame_valid <= 1'b1;
    frame       <= f;
    @(posedge clk_sys);
    frame_valid <= 1'b0;
    frame       <= ~f;
  endtask
endmodule

`default_nettype wire

// >>> verification/tb_accept_filter.sv
// Self-checking bench for the acceptance filter block
`default_nettype none

module tb_accept_filter
  import accept_filter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys   = 1'b0;
  logic              rst       = 1'b1;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              frame_valid;
  frame_type         frame;
  logic              hit_valid;
  logic              reject_valid;
  logic [3:0]        hit_filter;
  logic [3:0]        hit_bufptr;
  logic              hit_to_fifo;
  int                err_total = 0;
  int                n_tests   = 0;

  always #4 clk_sys = ~clk_sys;

  accept_filter u_dut (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .frame_valid  (frame_valid),
    .frame        (frame),
    .hit_valid    (hit_valid),
    .reject_valid (reject_valid),
    .hit_filter   (hit_filter),
    .hit_bufptr   (hit_bufptr),
    .hit_to_fifo  (hit_to_fifo)
  );

  can_frame_source u_src (
    .clk_sys     (clk_sys),
    .frame_valid (frame_valid),
    .frame       (frame)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Bit 4 of exp marks a hit; low nibble is the filter index then held
  task automatic fr_chk(input frame_type f, input logic [4:0] exp);
    u_src.send(f);
    #1;
    chk(hit_valid, exp[4]);
    chk(reject_valid, !exp[4]);
    chk(hit_filter, exp[3:0]);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    rd_chk(MSEL_LOW_ADDR, 16'h0000);
    rd_chk(MSEL_HIGH_ADDR, 16'h0000);
    $display("reset test done");
  endtask

  task automatic test_config;
    for (int n = 0; n < FILTER_COUNT; n++)
    begin
      wr(FILT_SID_BASE + 8'(n), {(n == 7) ? 11'h408 : 11'(n + 1), 1'b0,
         1'(n == 15), 3'h0});
      wr(FILT_EID_BASE + 8'(n), 16'h1000 + 16'(n));
    end
    wr(MASK_SID_BASE, 16'hFFE3);
    wr(MASK_SID_BASE + 8'd1, 16'hFFFC);
    wr(MASK_SID_BASE + 8'd2, 16'h8003);
    wr(MASK_EID_BASE, 16'hFFFF);
    wr(MASK_EID_BASE + 8'd1, 16'h0000);
    wr(MASK_EID_BASE + 8'd2, 16'hFFFF);
    wr(MSEL_LOW_ADDR, 16'h8000);
    wr(MSEL_HIGH_ADDR, 16'h4000);
    wr(BUFPTR_BASE, 16'h0F00);
    wr(BUFPTR_BASE + 8'd1, 16'h7000);
    wr(BUFPTR_BASE + 8'd3, 16'hA000);
    rd_chk(MASK_SID_BASE + 8'd1, 16'hFFE8);
    rd_chk(MSEL_LOW_ADDR, 16'h8000);
    rd_chk(MSEL_HIGH_ADDR, 16'h4000);
    rd_chk(FILT_EID_BASE + 8'd5, 16'h1005);
    rd_chk(8'hFF, 16'h0000);
    $display("config test done");
  endtask

  task automatic test_frames;
    fr_chk('{11'h003, 18'h01002, 1'b1}, 5'h12);
    chk(hit_bufptr, 4'hF);
    chk(hit_to_fifo, 1'b1);
    fr_chk('{11'h003, 18'h01003, 1'b1}, 5'h02);
    fr_chk('{11'h003, 18'h3FFFF, 1'b0}, 5'h12);
    fr_chk('{11'h004, 18'h01002, 1'b1}, 5'h02);
    fr_chk('{11'h7FF, 18'h01007, 1'b1}, 5'h17);
    chk(hit_bufptr, 4'h7);
    chk(hit_to_fifo, 1'b0);
    fr_chk('{11'h7FF, 18'h11007, 1'b1}, 5'h07);
    fr_chk('{11'h010, 18'h2ABCD, 1'b1}, 5'h1F);
    chk(hit_bufptr, 4'hA);
    fr_chk('{11'h010, 18'h00000, 1'b0}, 5'h0F);
    rd_chk(STATUS_ADDR, 16'h01FA);
    $display("frame test done");
  endtask

  // Filter 0 first on mask 0, then moved to mask 1 with type mode set
  task automatic test_mask_pick;
    fr_chk('{11'h001, 18'h01000, 1'b1}, 5'h10);
    chk(hit_bufptr, 4'h0);
    chk(hit_to_fifo, 1'b0);
    wr(MSEL_LOW_ADDR, 16'h8001);
    rd_chk(MSEL_LOW_ADDR, 16'h8001);
    fr_chk('{11'h001, 18'h3FFFF, 1'b0}, 5'h10);
    fr_chk('{11'h001, 18'h01000, 1'b1}, 5'h00);
    $display("mask pick test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset;
    test_config;
    test_frames;
    test_mask_pick;
    stop_test;
  end

  // About fifteen times the expected run length
  initial
  begin
    #(8 * 2000);
    err_total++;
    stop_test;
  end
endmodule

`default_nettype wire
